// >>> hw/lsi_dev_end.sv
// Module end: two-wire slave transport of the tunable source
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "lsi_map.svh"
module lsi_dev_end
  import lsi_pkg::*;
#(
  parameter logic [2:0] RATE_CODE = `LSI_RATE_STD,
  parameter int TIMEOUT_CYC = `LSI_TIMEOUT_CYC,
  parameter int STALL_CYC = `LSI_STALL_CYC
)(
  input wire logic CORE_CLK,
  input wire logic RESET,
  lsi_link_if.dev LINK,
  input wire logic ADDR_STRAP_BIT0,
  input wire logic ADDR_STRAP_BIT1,
  input wire logic ADDR_STRAP_BIT2,
  input wire logic IFACE_SEL_STRAP0,
  input wire logic IFACE_SEL_STRAP1,
  input wire logic [31:0] RESP_WORD,
  input wire logic RESP_LOAD,
  input wire logic [31:0] PEND_WORD,
  output logic [31:0] CMD_WORD,
  output logic CMD_VALID,
  output logic [1:0] IFACE_MODE,
  output logic [6:0] OWN_ADDR,
  output logic [15:0] LINK_SPEED_CAPABILITY
);
  // ==========================================================
  // Synchronisers
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [2:0] clr_q;
  logic [4:0] strap_q0;
  logic [4:0] strap_q1;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic clr_rise;
  logic enabled;

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      clr_q <= 3'h7;
    end
    else
    begin
      scl_q <= {scl_q[1:0], LINK.serial_clock_pin};
      sda_q <= {sda_q[1:0], LINK.serial_data};
      clr_q <= {clr_q[1:0], LINK.comms_clear_n};
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    strap_q0 <= {IFACE_SEL_STRAP1, IFACE_SEL_STRAP0, ADDR_STRAP_BIT2,
      ADDR_STRAP_BIT1, ADDR_STRAP_BIT0};
    strap_q1 <= strap_q0;
  end

  // Straps are held for the whole reset; taken only while it stands
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      OWN_ADDR <= {`LSI_ADDR_HI, strap_q1[2:0]};
      IFACE_MODE <= strap_q1[4:3];
    end
  end

  assign scl_rise = scl_q[1] && !scl_q[2];
  assign scl_fall = !scl_q[1] && scl_q[2];
  assign start_seen = scl_q[1] && scl_q[2] && !sda_q[1] && sda_q[2];
  assign stop_seen = scl_q[1] && scl_q[2] && sda_q[1] && !sda_q[2];
  assign clr_rise = clr_q[1] && !clr_q[2];
  assign enabled = IFACE_MODE == `LSI_MODE_I2C;

  // ==========================================================
  // Byte engine
  lsi_dev_state_t state;
  logic [3:0] bit_idx;
  logic [2:0] byte_cnt;
  logic [7:0] shreg;
  logic [31:0] cmd_buf;
  logic [31:0] rd_sh;
  logic [31:0] resp_buf;
  logic resp_ready;
  logic busy;
  logic rw;
  logic cmd_done;
  logic stall_hit;
  logic [15:0] idle_cnt;

  assign cmd_done = stop_seen && !clr_rise && !stall_hit
    && state == D_WRITE && byte_cnt == `LSI_PKT_BYTES;

  // Watchdog: a silent clock mid-frame frees the data line
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET || scl_rise || scl_fall || state == D_IDLE)
      idle_cnt <= 16'h0000;
    else
      idle_cnt <= idle_cnt + 16'h0001;
  end
  assign stall_hit = idle_cnt == 16'(STALL_CYC - 1);

  // Only the data line is ever driven; the clock is never held
  always_ff @(posedge CORE_CLK)
  begin
    LINK.sda_d_o <= 1'b0;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET || clr_rise || stall_hit)
    begin
      state <= D_IDLE;
      LINK.sda_d_oe <= 1'b0;
      bit_idx <= 4'h0;
      byte_cnt <= 3'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      cmd_buf <= 32'h00000000;
      rd_sh <= 32'h00000000;
    end
    else if (start_seen)
    begin
      // Repeated start behaves as a fresh start
      state <= enabled ? D_ADDR : D_SKIP;
      LINK.sda_d_oe <= 1'b0;
      // Start's own clock fall wraps this to zero before the first bit
      bit_idx <= 4'hf;
      byte_cnt <= 3'h0;
    end
    else if (stop_seen)
    begin
      state <= D_IDLE;
      LINK.sda_d_oe <= 1'b0;
    end
    else
    begin
      unique case (state)
        D_IDLE, D_SKIP:
        begin
          LINK.sda_d_oe <= 1'b0;
        end
        D_ADDR:
        begin
          if (scl_rise && bit_idx != 4'h8)
            shreg <= {shreg[6:0], sda_q[1]};
          if (scl_fall)
          begin
            if (bit_idx == 4'h7)
            begin
              // Read refused until a response stands; writes refused
              // while busy, so a poll sees a missing acknowledge
              if (shreg[7:1] == OWN_ADDR && (shreg[0] ? resp_ready
                : !busy))
              begin
                LINK.sda_d_oe <= 1'b1;
                rw <= shreg[0];
                bit_idx <= 4'h8;
              end
              else
                state <= D_SKIP;
            end
            else if (bit_idx == 4'h8)
            begin
              bit_idx <= 4'h0;
              if (rw)
              begin
                state <= D_READ;
                rd_sh <= resp_buf;
                LINK.sda_d_oe <= !resp_buf[31];
              end
              else
              begin
                state <= D_WRITE;
                LINK.sda_d_oe <= 1'b0;
              end
            end
            else
              bit_idx <= bit_idx + 4'h1;
          end
        end
        D_WRITE:
        begin
          if (scl_rise && bit_idx != 4'h8)
            shreg <= {shreg[6:0], sda_q[1]};
          if (scl_fall)
          begin
            if (bit_idx == 4'h7)
            begin
              bit_idx <= 4'h8;
              // A fifth byte is not acknowledged
              if (byte_cnt != `LSI_PKT_BYTES)
              begin
                cmd_buf <= {cmd_buf[23:0], shreg};
                byte_cnt <= byte_cnt + 3'h1;
                LINK.sda_d_oe <= 1'b1;
              end
            end
            else if (bit_idx == 4'h8)
            begin
              bit_idx <= 4'h0;
              LINK.sda_d_oe <= 1'b0;
            end
            else
              bit_idx <= bit_idx + 4'h1;
          end
        end
        D_READ:
        begin
          if (scl_rise && bit_idx == 4'h8 && sda_q[1])
            state <= D_SKIP;
          if (scl_fall)
          begin
            if (bit_idx != 4'h8)
            begin
              rd_sh <= {rd_sh[30:0], 1'b0};
              LINK.sda_d_oe <= bit_idx != 4'h7 && !rd_sh[30];
              bit_idx <= bit_idx + 4'h1;
            end
            else
            begin
              bit_idx <= 4'h0;
              byte_cnt <= byte_cnt + 3'h1;
              if (byte_cnt == `LSI_PKT_BYTES - 3'h1)
                state <= D_SKIP;
              else
                LINK.sda_d_oe <= !rd_sh[31];
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Command hand-off and busy
  logic [31:0] wait_cnt;

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      CMD_VALID <= 1'b0;
      CMD_WORD <= 32'h00000000;
    end
    else
    begin
      CMD_VALID <= cmd_done;
      if (cmd_done)
        CMD_WORD <= cmd_buf;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET || clr_rise)
    begin
      busy <= 1'b0;
      LINK.cmd_busy_n <= 1'b1;
      resp_ready <= 1'b0;
      resp_buf <= 32'h00000000;
      wait_cnt <= 32'h00000000;
    end
    else if (cmd_done)
    begin
      busy <= 1'b1;
      LINK.cmd_busy_n <= 1'b0;
      resp_ready <= 1'b0;
      wait_cnt <= 32'h00000000;
    end
    else if (busy && RESP_LOAD)
    begin
      busy <= 1'b0;
      LINK.cmd_busy_n <= 1'b1;
      resp_ready <= 1'b1;
      resp_buf <= RESP_WORD;
    end
    else if (busy && wait_cnt == 32'(TIMEOUT_CYC - 1))
    begin
      busy <= 1'b0;
      LINK.cmd_busy_n <= 1'b1;
      resp_ready <= 1'b1;
      resp_buf <= PEND_WORD;
    end
    else if (busy)
      wait_cnt <= wait_cnt + 32'h00000001;
  end

  // Edges are found by oversampling at the core rate, so any lower
  // rate code is served as well as the one reported
  always_ff @(posedge CORE_CLK)
  begin
    LINK_SPEED_CAPABILITY <= {`LSI_CAP_RSVD, RATE_CODE};
  end
endmodule
`default_nettype wire

// >>> hw/lsi_map.svh
// Offsets, field positions, codes and timing counts of the link
`ifndef LSI_MAP_SVH
`define LSI_MAP_SVH
`define LSI_ADDR_HI 4'hc
`define LSI_PKT_BYTES 3'h4
`define LSI_RATE_STD 3'h0
`define LSI_RATE_FAST 3'h1
`define LSI_RATE_HS 3'h2
`define LSI_CAP_RSVD 13'h0000
`define LSI_MODE_SPI 2'h0
`define LSI_MODE_RS232 2'h1
`define LSI_MODE_I2C 2'h2
`define LSI_MODE_VEND 2'h3
`define LSI_CLK_NS 100
`define LSI_SCL_HALF_NS 5000
`define LSI_SCL_HALF_CYC (`LSI_SCL_HALF_NS / `LSI_CLK_NS)
`define LSI_STALL_US 100
`define LSI_STALL_CYC (`LSI_STALL_US * 1000 / `LSI_CLK_NS)
`define LSI_TIMEOUT_CYC 100000
`define LSI_REG_CTRL 4'h0
`define LSI_REG_TARGET 4'h1
`define LSI_REG_TX 4'h2
`define LSI_REG_RX 4'h3
`define LSI_REG_STATUS 4'h4
`define LSI_CTRL_GO 0
`define LSI_CTRL_RW 1
`define LSI_CTRL_CLR 2
`endif

// >>> hw/lsi_pkg.sv
// Types shared by both ends of the link
package lsi_pkg;
  typedef enum logic [4:0] {
    D_IDLE = 5'b00001,
    D_ADDR = 5'b00010,
    D_WRITE = 5'b00100,
    D_READ = 5'b01000,
    D_SKIP = 5'b10000
  } lsi_dev_state_t;
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_START = 4'b0010,
    H_BIT = 4'b0100,
    H_STOP = 4'b1000
  } lsi_host_state_t;
endpackage

// >>> hw/lsi_link_if.sv
// Open-drain two-wire link between host and module
`timescale 1ns/1ns
`default_nettype none
interface lsi_link_if;
  logic scl_h_o;
  logic scl_h_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic cmd_busy_n;
  logic comms_clear_n;
  logic serial_clock_pin;
  logic serial_data;
  // Wired-AND with pull-ups
  assign serial_clock_pin = !(scl_h_oe && !scl_h_o);
  assign serial_data = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));
  modport dev (
    input serial_clock_pin,
    input serial_data,
    input comms_clear_n,
    output sda_d_o,
    output sda_d_oe,
    output cmd_busy_n
  );
  modport host (
    input serial_clock_pin,
    input serial_data,
    input cmd_busy_n,
    output scl_h_o,
    output scl_h_oe,
    output sda_h_o,
    output sda_h_oe,
    output comms_clear_n
  );
endinterface
`default_nettype wire

// >>> hw/lsi_host_end.sv
// Host end: two-wire master that writes commands and reads responses
`timescale 1ns/1ns
`default_nettype none
`include "lsi_map.svh"
module lsi_host_end
  import lsi_pkg::*;
#(
  parameter int HALF_CYC = `LSI_SCL_HALF_CYC
)(
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  lsi_link_if.host LINK
);
  // ==========================================================
  // Registers
  logic [1:0] sda_q;
  logic [1:0] busy_q;
  logic [6:0] target;
  logic [31:0] tx_word;
  logic [31:0] tx_sh;
  logic [31:0] rx_word;
  logic done;
  logic nack;
  logic go;
  lsi_host_state_t state;

  assign go = REG_WR && REG_ADDR == `LSI_REG_CTRL
    && REG_WDATA[`LSI_CTRL_GO] && state == H_IDLE;

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      sda_q <= 2'h3;
      busy_q <= 2'h3;
    end
    else
    begin
      sda_q <= {sda_q[0], LINK.serial_data};
      busy_q <= {busy_q[0], LINK.cmd_busy_n};
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      target <= 7'h00;
      tx_word <= 32'h00000000;
      LINK.comms_clear_n <= 1'b1;
    end
    else if (REG_WR)
    begin
      if (REG_ADDR == `LSI_REG_TARGET)
        target <= REG_WDATA[6:0];
      if (REG_ADDR == `LSI_REG_TX)
        tx_word <= REG_WDATA;
      if (REG_ADDR == `LSI_REG_CTRL)
        LINK.comms_clear_n <= !REG_WDATA[`LSI_CTRL_CLR];
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET || !REG_RD)
      REG_RDATA <= 32'h00000000;
    else
      unique case (REG_ADDR)
        `LSI_REG_TARGET: REG_RDATA <= {25'h0000000, target};
        `LSI_REG_TX: REG_RDATA <= tx_word;
        `LSI_REG_RX: REG_RDATA <= rx_word;
        `LSI_REG_STATUS: REG_RDATA <= {28'h0000000, !busy_q[1], nack,
          done, state != H_IDLE};
        default: REG_RDATA <= 32'h00000000;
      endcase
  end

  // ==========================================================
  // Bit engine
  logic [15:0] tick_cnt;
  logic tick;
  logic drive_now;
  logic drive_low;
  logic rw;
  logic [3:0] bit_idx;
  logic [2:0] byte_idx;
  logic [7:0] sh;

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET || state == H_IDLE || tick)
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= tick_cnt + 16'h0001;
  end
  assign tick = tick_cnt == 16'(HALF_CYC - 1);

  // Reads acknowledge bytes one to three and refuse the fourth
  assign drive_low = (bit_idx != 4'h8)
    ? ((byte_idx == 3'h0 || !rw) && !sh[7])
    : (rw && byte_idx != 3'h0 && byte_idx != `LSI_PKT_BYTES);

  always_ff @(posedge CORE_CLK)
  begin
    LINK.scl_h_o <= 1'b0;
    LINK.sda_h_o <= 1'b0;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      state <= H_IDLE;
      LINK.scl_h_oe <= 1'b0;
      LINK.sda_h_oe <= 1'b0;
      drive_now <= 1'b0;
      rw <= 1'b0;
      bit_idx <= 4'h0;
      byte_idx <= 3'h0;
      sh <= 8'h00;
      tx_sh <= 32'h00000000;
      rx_word <= 32'h00000000;
      done <= 1'b0;
      nack <= 1'b0;
    end
    else
      unique case (state)
        H_IDLE:
        begin
          if (go)
          begin
            state <= H_START;
            LINK.sda_h_oe <= 1'b1;
            rw <= REG_WDATA[`LSI_CTRL_RW];
            done <= 1'b0;
            nack <= 1'b0;
            tx_sh <= tx_word;
          end
        end
        H_START:
        begin
          if (tick)
          begin
            state <= H_BIT;
            LINK.scl_h_oe <= 1'b1;
            bit_idx <= 4'h0;
            byte_idx <= 3'h0;
            sh <= {target, rw};
            drive_now <= 1'b1;
          end
        end
        H_BIT:
        begin
          // Data moves a cycle after the clock falls, never with it
          if (drive_now)
          begin
            drive_now <= 1'b0;
            LINK.sda_h_oe <= drive_low;
          end
          else if (tick && LINK.scl_h_oe)
            LINK.scl_h_oe <= 1'b0;
          else if (tick)
          begin
            LINK.scl_h_oe <= 1'b1;
            drive_now <= 1'b1;
            if (bit_idx != 4'h8)
            begin
              sh <= {sh[6:0], sda_q[1]};
              bit_idx <= bit_idx + 4'h1;
            end
            else
            begin
              bit_idx <= 4'h0;
              byte_idx <= byte_idx + 3'h1;
              sh <= tx_sh[31:24];
              tx_sh <= {tx_sh[23:0], 8'h00};
              if (rw && byte_idx != 3'h0)
                rx_word <= {rx_word[23:0], sh};
              if ((byte_idx == 3'h0 || !rw) && sda_q[1])
              begin
                nack <= 1'b1;
                state <= H_STOP;
              end
              else if (byte_idx == `LSI_PKT_BYTES)
                state <= H_STOP;
            end
          end
        end
        H_STOP:
        begin
          if (drive_now)
          begin
            drive_now <= 1'b0;
            LINK.sda_h_oe <= 1'b1;
          end
          else if (tick && LINK.scl_h_oe)
            LINK.scl_h_oe <= 1'b0;
          else if (tick)
          begin
            LINK.sda_h_oe <= 1'b0;
            state <= H_IDLE;
            done <= 1'b1;
          end
        end
      endcase
  end
  // Bytes follow without pause, well inside one byte time
endmodule
`default_nettype wire

// >>> dv/lsi_link_asserts.sv
// Link checker beside the interface joining host and module ends
`timescale 1ns/1ns
`default_nettype none
module lsi_link_asserts #(
  parameter int TIMEOUT_CYC = 3000
)(
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic scl_h_o,
  input wire logic scl_h_oe,
  input wire logic sda_h_o,
  input wire logic sda_h_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic cmd_busy_n,
  input wire logic comms_clear_n,
  input wire logic serial_clock_pin,
  input wire logic serial_data
);
  // Longest byte of zeros plus margin at a half bit of 10 cycles
  localparam int MAX_DRIVE = 400;
  localparam int MAX_LOW = 1000;
  int busy_cnt;
  int low_cnt;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  // ==========================================================
  // Helper counters
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET || cmd_busy_n)
      busy_cnt <= 0;
    else
      busy_cnt <= busy_cnt + 1;
  end
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET || serial_clock_pin)
      low_cnt <= 0;
    else
      low_cnt <= low_cnt + 1;
  end
  // ==========================================================
  // Assertions
  a_open_drain: assert property (!sda_d_o && !scl_h_o && !sda_h_o)
    else $error("open-drain output value not zero");
  a_no_stretch: assert property (!serial_clock_pin |-> scl_h_oe)
    else $error("clock line low without host pulling it");
  a_sda_stable: assert property (
    serial_clock_pin && $past(serial_clock_pin) |-> $stable(sda_d_oe))
    else $error("module moved data line while clock high");
  a_busy_cause: assert property (
    $fell(cmd_busy_n) |-> $past(serial_data, 2) && $past(serial_clock_pin, 2))
    else $error("busy asserted without a finished frame");
  a_busy_bound: assert property (busy_cnt <= TIMEOUT_CYC + 8)
    else $error("busy held past the command timeout");
  a_clear_idle: assert property (
    $rose(comms_clear_n) |-> ##[1:6] (cmd_busy_n && !sda_d_oe))
    else $error("clear rise did not idle the module");
  a_drive_bound: assert property (
    $rose(sda_d_oe) |-> ##[1:MAX_DRIVE] !sda_d_oe)
    else $error("module held data line too long");
  a_pause_bound: assert property (low_cnt <= MAX_LOW)
    else $error("clock line low longer than a byte time");
  c_start: cover property ($fell(serial_data) && serial_clock_pin && sda_h_oe);
  c_busy: cover property ($fell(cmd_busy_n));
  c_clear: cover property ($rose(comms_clear_n));
  c_drive: cover property ($rose(sda_d_oe));
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the host and module ends of the link
`timescale 1ns/1ns
`default_nettype none
`include "lsi_map.svh"
module testbench;
  localparam int HALF = 10;
  localparam int TO = 3000;
  localparam logic [2:0] RATE = `LSI_RATE_FAST;
  logic core_clk;
  logic reset;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, resp_word, pend_word, cmd_word;
  logic reg_wr, reg_rd, resp_load, cmd_valid;
  logic [2:0] addr_strap;
  logic [1:0] mode_strap, iface_mode, m_mode;
  logic [6:0] own_addr, own;
  logic [15:0] cap;
  logic [31:0] rnd, m_resp, m_cmd;
  logic m_busy, m_ready, m_have;
  logic [1:0] modes [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  int failures, cmp_count, n_valid, m_valid;
  lsi_link_if link();
  lsi_host_end #(.HALF_CYC(HALF)) i_lsi_host_end (
    .CORE_CLK(core_clk), .RESET(reset), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .LINK(link.host));
  lsi_dev_end #(.RATE_CODE(RATE), .TIMEOUT_CYC(TO)) i_lsi_dev_end (
    .CORE_CLK(core_clk), .RESET(reset), .LINK(link.dev),
    .ADDR_STRAP_BIT0(addr_strap[0]), .ADDR_STRAP_BIT1(addr_strap[1]),
    .ADDR_STRAP_BIT2(addr_strap[2]), .IFACE_SEL_STRAP0(mode_strap[0]),
    .IFACE_SEL_STRAP1(mode_strap[1]), .RESP_WORD(resp_word),
    .RESP_LOAD(resp_load), .PEND_WORD(pend_word), .CMD_WORD(cmd_word),
    .CMD_VALID(cmd_valid), .IFACE_MODE(iface_mode), .OWN_ADDR(own_addr),
    .LINK_SPEED_CAPABILITY(cap));
  lsi_link_asserts #(.TIMEOUT_CYC(TO)) i_lsi_link_asserts (
    .CORE_CLK(core_clk), .RESET(reset), .scl_h_o(link.scl_h_o),
    .scl_h_oe(link.scl_h_oe), .sda_h_o(link.sda_h_o),
    .sda_h_oe(link.sda_h_oe), .sda_d_o(link.sda_d_o),
    .sda_d_oe(link.sda_d_oe), .cmd_busy_n(link.cmd_busy_n),
    .comms_clear_n(link.comms_clear_n),
    .serial_clock_pin(link.serial_clock_pin),
    .serial_data(link.serial_data));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Gap cycle after each strobe so no signal is assigned twice a step
  task automatic reg_wrt(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic reg_rdt(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask
  // Behavioural model decides acceptance before the frame runs
  task automatic frame(input logic rd, input logic [6:0] a,
      input logic [31:0] w);
    logic [31:0] s;
    logic ok;
    int n;
    ok = a == own && m_mode == `LSI_MODE_I2C && !m_busy && (!rd || m_ready);
    reg_wrt(`LSI_REG_TX, w);
    reg_wrt(`LSI_REG_TARGET, {25'h0, a});
    reg_wrt(`LSI_REG_CTRL, {30'h0, rd, 1'b1});
    s = 32'h0;
    n = 0;
    while (s[1] !== 1'b1 && n < 4000)
    begin
      reg_rdt(`LSI_REG_STATUS, s);
      n++;
    end
    chk("done", 32'h1, {31'h0, s[1]});
    chk("nack", {31'h0, !ok}, {31'h0, s[2]});
    if (ok && rd)
    begin
      reg_rdt(`LSI_REG_RX, s);
      chk("rx_word", m_resp, s);
    end
    if (ok && !rd)
    begin
      m_cmd = w;
      m_have = 1'b1;
      m_busy = 1'b1;
      m_ready = 1'b0;
      m_valid++;
    end
    repeat (100) @(posedge core_clk);
    if (m_have)
      chk("cmd_word", m_cmd, cmd_word);
    chk("busy_n", {31'h0, !m_busy}, {31'h0, link.cmd_busy_n});
    chk("valid_count", m_valid, n_valid);
  endtask
  task automatic load(input logic [31:0] w);
    resp_word <= w;
    resp_load <= 1'b1;
    @(posedge core_clk);
    resp_load <= 1'b0;
    @(posedge core_clk);
    m_resp = w;
    m_ready = 1'b1;
    m_busy = 1'b0;
  endtask
  task automatic do_reset(input logic [1:0] m);
    rnd = lfsr(rnd);
    addr_strap <= rnd[2:0];
    mode_strap <= m;
    reset <= 1'b1;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    own = {`LSI_ADDR_HI, rnd[2:0]};
    m_mode = m;
    m_busy = 1'b0;
    m_ready = 1'b0;
    m_have = 1'b0;
    @(posedge core_clk);
    chk("own_addr", {25'h0, own}, {25'h0, own_addr});
    chk("iface_mode", {30'h0, m}, {30'h0, iface_mode});
    chk("capability", {29'h0, RATE}, {16'h0, cap});
    addr_strap <= ~rnd[2:0];
    repeat (4) @(posedge core_clk);
    chk("held_addr", {25'h0, own}, {25'h0, own_addr});
  endtask
  // ==========================================================
  // Clock, watchdog, main sequence
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
    if (cmd_valid === 1'b1)
      n_valid++;
  initial
  begin
    repeat (60000) @(posedge core_clk);
    failures++;
    test_done();
  end
  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    resp_load = 1'b0;
    resp_word = 32'h0;
    rnd = lfsr(32'h3e);
    pend_word = rnd;
    foreach (modes[i])
    begin
      do_reset(modes[i]);
      frame(1'b0, own, rnd);
    end
    frame(1'b1, own, 32'h0);
    rnd = lfsr(rnd);
    load(rnd);
    repeat (2) frame(1'b1, own, 32'h0);
    rnd = lfsr(rnd);
    frame(1'b0, own ^ 7'h01, rnd);
    frame(1'b0, own, rnd);
    repeat (TO) @(posedge core_clk);
    // Late load after the timeout must be ignored
    load(~pend_word);
    m_resp = pend_word;
    frame(1'b1, own, 32'h0);
    rnd = lfsr(rnd);
    frame(1'b0, own, rnd);
    reg_wrt(`LSI_REG_CTRL, 32'h4);
    reg_wrt(`LSI_REG_CTRL, 32'h0);
    repeat (10) @(posedge core_clk);
    m_busy = 1'b0;
    m_ready = 1'b0;
    chk("busy_clear", 32'h1, {31'h0, link.cmd_busy_n});
    frame(1'b1, own, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
